/* File: design/adcc_pkg.sv */
package adcc_pkg;

  // Clock and converter clock figures.
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CONV_CLK_HZ     = 1_000_000;
  localparam int unsigned CONV_CLK_MIN_HZ = 200_000;
  localparam int unsigned CONV_CLK_MAX_HZ = 2_000_000;

  // The divider field holds the division ratio minus this offset.
  localparam int unsigned DIV_OFFSET = 2;
  localparam int unsigned DIV_W      = 9;
  localparam int unsigned CNT_W      = 10;
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / CONV_CLK_HZ - DIV_OFFSET);
  localparam logic [DIV_W-1:0] DIV_FIELD_FASTEST = DIV_W'(CLK_HZ / CONV_CLK_MAX_HZ - DIV_OFFSET);
  localparam logic [CNT_W-1:0] CNT_ONE   = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 10'h000;

  // Register byte addresses.
  localparam logic [31:0] ADDR_RESULT     = 32'h4000_5A00;
  localparam logic [31:0] ADDR_STATE      = 32'h4000_5A04;
  localparam logic [31:0] ADDR_CONTROL    = 32'h4000_5A08;
  localparam logic [31:0] ADDR_CLK_SOURCE = 32'h4000_5A0C;
  localparam logic [31:0] ADDR_CLK_DIV    = 32'h4000_5A10;
  localparam logic [31:0] ADDR_ROOT_GATE  = 32'h4000_5A14;
  localparam logic [31:0] ADDR_PATH_GATE  = 32'h4000_5A18;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_5A1C;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h4000_5A20;

  // Field layout.
  localparam int unsigned RESULT_W       = 12;
  localparam int unsigned DONE_BIT       = 0;
  localparam int unsigned START_BIT      = 0;
  localparam int unsigned CHANNEL_BIT    = 1;
  localparam int unsigned BATTERY_BIT    = 2;
  localparam int unsigned CONTROL_W      = 3;
  localparam int unsigned ROOT_GATE_BIT  = 7;
  localparam int unsigned PATH_GATE_BIT  = 0;
  localparam int unsigned SOURCE_BIT     = 0;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_START_BIT  = 1;
  localparam int unsigned IRQ_W          = 2;

  // Reset values.
  localparam logic [RESULT_W-1:0]  RESULT_RESET  = 12'h000;
  localparam logic [CONTROL_W-1:0] CONTROL_RESET = 3'h0;
  localparam logic [IRQ_W-1:0]     IRQ_RESET     = 2'h0;
  localparam logic                 SOURCE_FAST   = 1'b0;
  localparam logic [31:0]          WORD_ZERO     = 32'h0000_0000;

  typedef enum logic {
    ADCC_BUS_IDLE   = 1'b0,
    ADCC_BUS_ANSWER = 1'b1
  } adcc_bus_state_t;

endpackage : adcc_pkg

/* File: design/adcc_clock_divider.sv */
module adcc_clock_divider (
  input  wire logic                          clk_in,
  input  wire logic                          resetn_in,
  input  wire logic                          enable_in,
  input  wire logic [adcc_pkg::DIV_W-1:0]    ratio_field_in,
  output logic                               tick_out
);

  logic [adcc_pkg::CNT_W-1:0] count_q;
  logic [adcc_pkg::CNT_W-1:0] last_count;

  // The period is the field plus two cycles, so the counter runs 0 to field+1.
  assign last_count = {1'b0, ratio_field_in} + adcc_pkg::CNT_ONE;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q  <= adcc_pkg::CNT_ZERO;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      count_q  <= adcc_pkg::CNT_ZERO;
      tick_out <= 1'b0;
    end else if (count_q >= last_count) begin
      count_q  <= adcc_pkg::CNT_ZERO;
      tick_out <= 1'b1;
    end else begin
      count_q  <= count_q + adcc_pkg::CNT_ONE;
      tick_out <= 1'b0;
    end
  end

endmodule : adcc_clock_divider

/* File: design/adcc_conversion_control.sv */
module adcc_conversion_control (
  input  wire logic                             clk_in,
  input  wire logic                             resetn_in,
  input  wire logic [31:0]                      avs_address_in,
  input  wire logic                             avs_read_in,
  input  wire logic                             avs_write_in,
  input  wire logic [31:0]                      avs_writedata_in,
  input  wire logic [3:0]                       avs_byteenable_in,
  output logic      [31:0]                      avs_readdata_out,
  output logic                                  avs_waitrequest_out,
  output logic                                  irq_out,
  output logic                                  start_level_out,
  output logic                                  channel_sel_out,
  output logic                                  battery_measure_on_out,
  output logic                                  converter_clock_out,
  input  wire logic                             done_in,
  input  wire logic [adcc_pkg::RESULT_W-1:0]    result_in
);

  adcc_pkg::adcc_bus_state_t              bus_state_q;
  logic [31:0]                            readdata_d;
  logic [31:0]                            lane_mask;
  logic                                   commit_write;
  logic                                   hit_result;
  logic                                   hit_state;
  logic                                   hit_control;
  logic                                   hit_source;
  logic                                   hit_div;
  logic                                   hit_root;
  logic                                   hit_path;
  logic                                   hit_irq_status;
  logic                                   hit_irq_mask;

  logic [adcc_pkg::CONTROL_W-1:0]         control_q;
  logic [adcc_pkg::CONTROL_W-1:0]         control_d;
  logic [adcc_pkg::RESULT_W-1:0]          result_q;
  logic                                   done_flag_q;
  logic                                   source_q;
  logic [adcc_pkg::DIV_W-1:0]             div_field_q;
  logic                                   root_gate_q;
  logic                                   path_gate_q;
  logic [adcc_pkg::IRQ_W-1:0]             irq_status_q;
  logic [adcc_pkg::IRQ_W-1:0]             irq_mask_q;
  logic [adcc_pkg::IRQ_W-1:0]             irq_set;
  logic [adcc_pkg::IRQ_W-1:0]             irq_clear;

  logic                                   done_s1_q;
  logic                                   done_s2_q;
  logic                                   done_s3_q;
  logic                                   done_level_q;
  logic                                   done_rise;
  logic                                   start_rise;
  logic                                   divider_on;
  logic                                   divider_tick;

  // Avalon slave: one wait cycle, then the answer. The request is committed
  // only at the edge where waitrequest is seen low.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) &
                               (bus_state_q == adcc_pkg::ADCC_BUS_IDLE);
  assign commit_write = avs_write_in & (bus_state_q == adcc_pkg::ADCC_BUS_ANSWER);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_state_q <= adcc_pkg::ADCC_BUS_IDLE;
    end else begin
      case (bus_state_q)
        adcc_pkg::ADCC_BUS_IDLE: begin
          if (avs_read_in | avs_write_in) begin
            bus_state_q <= adcc_pkg::ADCC_BUS_ANSWER;
          end
        end
        adcc_pkg::ADCC_BUS_ANSWER: begin
          bus_state_q <= adcc_pkg::ADCC_BUS_IDLE;
        end
        default: begin
          bus_state_q <= adcc_pkg::ADCC_BUS_IDLE;
        end
      endcase
    end
  end

  // Address decode.
  always_comb begin
    hit_result     = 1'b0;
    hit_state      = 1'b0;
    hit_control    = 1'b0;
    hit_source     = 1'b0;
    hit_div        = 1'b0;
    hit_root       = 1'b0;
    hit_path       = 1'b0;
    hit_irq_status = 1'b0;
    hit_irq_mask   = 1'b0;
    if (avs_address_in == adcc_pkg::ADDR_RESULT) begin
      hit_result = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_STATE) begin
      hit_state = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_CONTROL) begin
      hit_control = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_CLK_SOURCE) begin
      hit_source = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_CLK_DIV) begin
      hit_div = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_ROOT_GATE) begin
      hit_root = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_PATH_GATE) begin
      hit_path = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_IRQ_STATUS) begin
      hit_irq_status = 1'b1;
    end else if (avs_address_in == adcc_pkg::ADDR_IRQ_MASK) begin
      hit_irq_mask = 1'b1;
    end
  end

  assign lane_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Read mux; unmapped addresses and unlisted bits read as zero.
  always_comb begin
    readdata_d = adcc_pkg::WORD_ZERO;
    if (hit_result) begin
      readdata_d[adcc_pkg::RESULT_W-1:0] = result_q;
    end else if (hit_state) begin
      readdata_d[adcc_pkg::DONE_BIT] = done_flag_q;
    end else if (hit_control) begin
      readdata_d[adcc_pkg::CONTROL_W-1:0] = control_q;
    end else if (hit_source) begin
      readdata_d[adcc_pkg::SOURCE_BIT] = source_q;
    end else if (hit_div) begin
      readdata_d[adcc_pkg::DIV_W-1:0] = div_field_q;
    end else if (hit_root) begin
      readdata_d[adcc_pkg::ROOT_GATE_BIT] = root_gate_q;
    end else if (hit_path) begin
      readdata_d[adcc_pkg::PATH_GATE_BIT] = path_gate_q;
    end else if (hit_irq_status) begin
      readdata_d[adcc_pkg::IRQ_W-1:0] = irq_status_q;
    end else if (hit_irq_mask) begin
      readdata_d[adcc_pkg::IRQ_W-1:0] = irq_mask_q;
    end
  end

  // Read data is sampled in the wait cycle and stands through the answer edge.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= adcc_pkg::WORD_ZERO;
    end else if (avs_read_in && bus_state_q == adcc_pkg::ADCC_BUS_IDLE) begin
      avs_readdata_out <= readdata_d;
    end
  end

  // Control register with byte-lane merge; only the three listed bits exist.
  always_comb begin
    control_d = (control_q & ~lane_mask[adcc_pkg::CONTROL_W-1:0]) |
                (avs_writedata_in[adcc_pkg::CONTROL_W-1:0] &
                 lane_mask[adcc_pkg::CONTROL_W-1:0]);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control_q <= adcc_pkg::CONTROL_RESET;
    end else if (commit_write && hit_control) begin
      control_q <= control_d;
    end
  end

  // A fresh start needs the bit to go from 0 to 1; rewriting 1 is not a start.
  assign start_rise = commit_write & hit_control &
                      control_d[adcc_pkg::START_BIT] &
                      ~control_q[adcc_pkg::START_BIT];

  assign start_level_out        = control_q[adcc_pkg::START_BIT];
  assign channel_sel_out        = control_q[adcc_pkg::CHANNEL_BIT];
  assign battery_measure_on_out = control_q[adcc_pkg::BATTERY_BIT];

  // The done line comes from the analog macro, outside this clock domain.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_in;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_level_q <= 1'b0;
    end else if (done_s2_q == done_s3_q) begin
      done_level_q <= done_s2_q;
    end
  end

  assign done_rise = (done_s2_q == done_s3_q) & done_s2_q & ~done_level_q;

  // The result word is not synchronised bit by bit: the macro holds it stable
  // while done is high, so it is safe to take it on the filtered done edge.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_q <= adcc_pkg::RESULT_RESET;
    end else if (done_rise) begin
      result_q <= result_in;
    end
  end

  // The flag is cleared by our own start edge, so software sees it low right
  // after starting even if the macro is slow to drop its done line.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_flag_q <= 1'b0;
    end else if (done_rise) begin
      done_flag_q <= 1'b1;
    end else if (start_rise) begin
      done_flag_q <= 1'b0;
    end
  end

  // Converter clock configuration.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      source_q <= adcc_pkg::SOURCE_FAST;
    end else if (commit_write && hit_source && avs_byteenable_in[0]) begin
      source_q <= avs_writedata_in[adcc_pkg::SOURCE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_field_q <= adcc_pkg::DIV_RESET;
    end else if (commit_write && hit_div) begin
      div_field_q <= (div_field_q & ~lane_mask[adcc_pkg::DIV_W-1:0]) |
                     (avs_writedata_in[adcc_pkg::DIV_W-1:0] &
                      lane_mask[adcc_pkg::DIV_W-1:0]);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      root_gate_q <= 1'b0;
    end else if (commit_write && hit_root && avs_byteenable_in[0]) begin
      root_gate_q <= avs_writedata_in[adcc_pkg::ROOT_GATE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      path_gate_q <= 1'b0;
    end else if (commit_write && hit_path && avs_byteenable_in[0]) begin
      path_gate_q <= avs_writedata_in[adcc_pkg::PATH_GATE_BIT];
    end
  end

  // Only the oscillator source exists here; any other selection stops the
  // divider rather than producing a clock of unknown rate.
  assign divider_on = root_gate_q & (source_q == adcc_pkg::SOURCE_FAST);

  adcc_clock_divider u_divider (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .enable_in      (divider_on),
    .ratio_field_in (div_field_q),
    .tick_out       (divider_tick)
  );

  // The converter clock is a one-cycle pulse per divided period; the default
  // field gives 1 MHz, but software owns keeping it inside the legal band.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      converter_clock_out <= 1'b0;
    end else begin
      converter_clock_out <= divider_tick & path_gate_q;
    end
  end

  // Interrupt status: a new event wins over a clear in the same cycle.
  always_comb begin
    irq_set                          = adcc_pkg::IRQ_RESET;
    irq_set[adcc_pkg::IRQ_DONE_BIT]  = done_rise;
    irq_set[adcc_pkg::IRQ_START_BIT] = start_rise;
    irq_clear = adcc_pkg::IRQ_RESET;
    if (commit_write && hit_irq_status && avs_byteenable_in[0]) begin
      irq_clear = avs_writedata_in[adcc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_status_q <= adcc_pkg::IRQ_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask_q <= adcc_pkg::IRQ_RESET;
    end else if (commit_write && hit_irq_mask && avs_byteenable_in[0]) begin
      irq_mask_q <= avs_writedata_in[adcc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule : adcc_conversion_control

/* File: dv/adcc_conversion_control_chk.sv */
module adcc_conversion_control_chk (
  input wire logic                          clk_in,
  input wire logic                          resetn_in,
  input wire logic [31:0]                   avs_address_in,
  input wire logic                          avs_read_in,
  input wire logic                          avs_write_in,
  input wire logic [31:0]                   avs_writedata_in,
  input wire logic [3:0]                    avs_byteenable_in,
  input wire logic [31:0]                   avs_readdata_out,
  input wire logic                          avs_waitrequest_out,
  input wire logic                          irq_out,
  input wire logic                          start_level_out,
  input wire logic                          channel_sel_out,
  input wire logic                          battery_measure_on_out,
  input wire logic                          converter_clock_out,
  input wire logic                          done_in,
  input wire logic [adcc_pkg::RESULT_W-1:0] result_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  logic rd_ok;
  logic wr_ctl;
  logic mapped;
  assign rd_ok  = avs_read_in && !avs_waitrequest_out;
  assign wr_ctl = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
                  && avs_address_in == adcc_pkg::ADDR_CONTROL;
  assign mapped = avs_address_in inside {adcc_pkg::ADDR_RESULT, adcc_pkg::ADDR_STATE,
    adcc_pkg::ADDR_CONTROL, adcc_pkg::ADDR_CLK_SOURCE, adcc_pkg::ADDR_CLK_DIV,
    adcc_pkg::ADDR_ROOT_GATE, adcc_pkg::ADDR_PATH_GATE, adcc_pkg::ADDR_IRQ_STATUS,
    adcc_pkg::ADDR_IRQ_MASK};

  property p_start_follows;
    wr_ctl |=> start_level_out == $past(avs_writedata_in[0]);
  endproperty
  a_start_follows: assert property (p_start_follows)
    else $error("start level does not follow the control write");
  property p_start_cause;
    $changed(start_level_out) |-> $past(wr_ctl);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start level moved without a control write");
  property p_chan;
    $changed(channel_sel_out) |-> $past(wr_ctl) && channel_sel_out == $past(avs_writedata_in[1]);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel select moved without a matching write");
  property p_batt;
    wr_ctl |=> battery_measure_on_out == $past(avs_writedata_in[2]);
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery enable does not follow the control write");
  property p_result_bits;
    rd_ok && avs_address_in == adcc_pkg::ADDR_RESULT |-> avs_readdata_out[31:12] == 20'h00000;
  endproperty
  a_result_bits: assert property (p_result_bits)
    else $error("result upper bits not zero");
  property p_state_bits;
    rd_ok && avs_address_in == adcc_pkg::ADDR_STATE |-> avs_readdata_out[31:1] == 31'h00000000;
  endproperty
  a_state_bits: assert property (p_state_bits)
    else $error("state upper bits not zero");
  property p_ctrl_read;
    rd_ok && avs_address_in == adcc_pkg::ADDR_CONTROL |-> avs_readdata_out ==
      {29'h00000000, battery_measure_on_out, channel_sel_out, start_level_out};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read differs from control outputs");
  property p_unmapped;
    rd_ok && !mapped |-> avs_readdata_out == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_clk_pulse;
    converter_clock_out |=> !converter_clock_out;
  endproperty
  a_clk_pulse: assert property (p_clk_pulse)
    else $error("converter clock pulse longer than one cycle");
endmodule : adcc_conversion_control_chk

bind adcc_conversion_control adcc_conversion_control_chk adcc_conversion_control_chk_inst (
  .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
  .start_level_out(start_level_out), .channel_sel_out(channel_sel_out),
  .battery_measure_on_out(battery_measure_on_out), .converter_clock_out(converter_clock_out),
  .done_in(done_in), .result_in(result_in));

/* File: dv/adcc_conv_model.sv */
module adcc_conv_model (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        start_level_in,
  input  wire logic        conv_tick_in,
  input  wire logic [11:0] level_in,
  output logic             done_out,
  output logic [11:0]      result_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       start_prev_q;
  logic       busy_q;
  logic [1:0] tick_cnt_q;
  logic [11:0] held_q;
  // A conversion needs converter clock ticks, so a gated or halted clock stalls it.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_prev_q <= 1'b0;
      busy_q       <= 1'b0;
      tick_cnt_q   <= 2'h0;
      held_q       <= 12'h000;
      done_out     <= 1'b0;
    end else begin
      start_prev_q <= start_level_in;
      if (start_level_in && !start_prev_q) begin
        done_out   <= 1'b0;
        busy_q     <= 1'b1;
        tick_cnt_q <= 2'h0;
        held_q     <= level_in;
      end else if (busy_q && conv_tick_in) begin
        tick_cnt_q <= tick_cnt_q + 2'h1;
        if (tick_cnt_q == 2'h3) begin
          busy_q   <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
  // The output is only held while done is high; otherwise it shows the inverse.
  assign result_out = done_out ? held_q : ~held_q;
endmodule : adcc_conv_model

/* File: dv/adcc_conversion_control_tb.sv */
module adcc_conversion_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} adcc_note_t;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [31:0] bus_addr = 32'h00000000;
  logic        bus_rd = 1'b0;
  logic        bus_wr = 1'b0;
  logic [31:0] bus_wdata = 32'h00000000;
  logic [3:0]  bus_be = 4'hF;
  logic [31:0] bus_rdata;
  logic        bus_wait, irq, start_lvl, chan, batt, conv_clk, done;
  logic [11:0] result;
  logic [11:0] level = 12'h000;
  logic [31:0] d;
  adcc_note_t  note;
  adcc_note_t  notes[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          g;
  localparam logic [31:0] ZERO_AT [9] = '{adcc_pkg::ADDR_RESULT, adcc_pkg::ADDR_STATE,
    adcc_pkg::ADDR_CONTROL, adcc_pkg::ADDR_CLK_SOURCE, adcc_pkg::ADDR_ROOT_GATE,
    adcc_pkg::ADDR_PATH_GATE, adcc_pkg::ADDR_IRQ_STATUS, adcc_pkg::ADDR_IRQ_MASK, 32'h40005A24};

  adcc_conversion_control adcc_conversion_control_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(bus_addr), .avs_read_in(bus_rd), .avs_write_in(bus_wr),
    .avs_writedata_in(bus_wdata), .avs_byteenable_in(bus_be), .avs_readdata_out(bus_rdata),
    .avs_waitrequest_out(bus_wait), .irq_out(irq), .start_level_out(start_lvl),
    .channel_sel_out(chan), .battery_measure_on_out(batt), .converter_clock_out(conv_clk),
    .done_in(done), .result_in(result));
  adcc_conv_model adcc_conv_model_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .start_level_in(start_lvl), .conv_tick_in(conv_clk), .level_in(level),
    .done_out(done), .result_out(result));

  always #5 clk_in = ~clk_in;

  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_write(input logic [31:0] a, input logic [31:0] w, input logic [3:0] be);
    @(posedge clk_in);
    bus_addr  <= a;
    bus_wdata <= w;
    bus_be    <= be;
    bus_wr    <= 1'b1;
    do @(posedge clk_in); while (bus_wait !== 1'b0);
    bus_wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{exp: e, mask: m});
    @(posedge clk_in);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    do @(posedge clk_in); while (bus_wait !== 1'b0);
    d = bus_rdata;
    bus_rd <= 1'b0;
  endtask : bus_read

  task automatic poll_state(input logic want);
    int n;
    n = 0;
    do begin
      bus_read(adcc_pkg::ADDR_STATE, 32'h0, 32'h0);
      n++;
    end while (d[0] !== want && n < 400);
    chk(32'(d[0]), 32'(want));
  endtask : poll_state

  task automatic count_pulses(output int cnt);
    cnt = 0;
    repeat (300) begin
      @(negedge clk_in);
      if (conv_clk === 1'b1) cnt++;
    end
  endtask : count_pulses

  // Cycles from one converter clock pulse to the next.
  task automatic pulse_gap(output int gap);
    gap = 0;
    do @(negedge clk_in); while (conv_clk !== 1'b1 && ++gap < 400);
    gap = 0;
    do begin
      @(negedge clk_in);
      gap++;
    end while (conv_clk !== 1'b1 && gap < 400);
  endtask : pulse_gap

  always @(posedge clk_in) begin
    if (bus_rd && bus_wait === 1'b0) begin
      note = notes.pop_front();
      chk(bus_rdata & note.mask, note.exp & note.mask);
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h0292));
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    foreach (ZERO_AT[i]) bus_read(ZERO_AT[i], 32'h0, 32'hFFFFFFFF);
    bus_read(adcc_pkg::ADDR_CLK_DIV, 32'(adcc_pkg::DIV_RESET), 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) begin
      bus_write(ZERO_AT[(i == 2) ? 8 : i], $urandom, 4'hF);
      bus_read(ZERO_AT[(i == 2) ? 8 : i], 32'h0, 32'hFFFFFFFF);
    end
    for (int i = 0; i < 8; i++) begin
      bus_write(adcc_pkg::ADDR_CONTROL, {29'($urandom), 3'(i)}, 4'hF);
      bus_read(adcc_pkg::ADDR_CONTROL, 32'(i), 32'hFFFFFFFF);
      chk({29'h0, batt, chan, start_lvl}, 32'(i));
    end
    bus_write(adcc_pkg::ADDR_CONTROL, 32'h0, 4'h0);
    bus_read(adcc_pkg::ADDR_CONTROL, 32'h7, 32'hFFFFFFFF);
    bus_write(adcc_pkg::ADDR_CONTROL, 32'h0, 4'hF);
    count_pulses(g);
    chk(32'(g), 32'h0);
    bus_write(adcc_pkg::ADDR_ROOT_GATE, 32'h80, 4'hF);
    count_pulses(g);
    chk(32'(g), 32'h0);
    bus_write(adcc_pkg::ADDR_PATH_GATE, 32'h1, 4'hF);
    pulse_gap(g);
    chk(32'(g), 32'(adcc_pkg::DIV_RESET) + 32'h2);
    bus_write(adcc_pkg::ADDR_CLK_SOURCE, 32'h1, 4'hF);
    count_pulses(g);
    chk(32'(g), 32'h0);
    bus_write(adcc_pkg::ADDR_CLK_SOURCE, 32'h0, 4'hF);
    bus_write(adcc_pkg::ADDR_CLK_DIV, 32'h30, 4'hF);
    pulse_gap(g);
    chk(32'(g), 32'h32);
    // The first pass unmasks the done event, the second leaves it masked.
    for (int i = 0; i < 2; i++) begin
      bus_write(adcc_pkg::ADDR_IRQ_MASK, 32'(i == 0), 4'hF);
      bus_write(adcc_pkg::ADDR_IRQ_STATUS, 32'h3, 4'hF);
      bus_write(adcc_pkg::ADDR_CONTROL, {29'h0, 1'(i), 1'(i == 0), 1'b0}, 4'hF);
      level <= 12'($urandom);
      bus_write(adcc_pkg::ADDR_CONTROL, {29'h0, 1'(i), 1'(i == 0), 1'b1}, 4'hF);
      poll_state(1'b0);
      poll_state(1'b1);
      bus_read(adcc_pkg::ADDR_RESULT, 32'(level), 32'hFFFFFFFF);
      chk(32'(irq), 32'(i == 0));
      bus_read(adcc_pkg::ADDR_IRQ_STATUS, 32'h3, 32'hFFFFFFFF);
      bus_write(adcc_pkg::ADDR_CONTROL, {29'h0, 1'(i), 1'(i == 0), 1'b1}, 4'hF);
      bus_read(adcc_pkg::ADDR_STATE, 32'h1, 32'hFFFFFFFF);
      bus_write(adcc_pkg::ADDR_IRQ_STATUS, 32'h3, 4'hF);
      bus_read(adcc_pkg::ADDR_IRQ_STATUS, 32'h0, 32'hFFFFFFFF);
      chk(32'(irq), 32'h0);
    end
    report_and_stop();
  end
endmodule : adcc_conversion_control_tb
